// ===== rtl/pma_defs.svh
/*
 * Offsets, reset values and code points of the operating-mode and alarm registers.
 * Assumes byte-wide registers on a 12-bit serial control address.
 */
`ifndef PMA_DEFS_SVH
`define PMA_DEFS_SVH

`define PMA_ADDR_W 12
`define PMA_OFS_MODE_B 12'h29a
`define PMA_OFS_MODE_C 12'h29b
`define PMA_OFS_MODE_D 12'h29c
`define PMA_OFS_SUMMARY 12'h2c0
`define PMA_OFS_STATUS 12'h2c1
`define PMA_OFS_MASK 12'h2c2

`define PMA_RST_MODE_B 8'h0f
`define PMA_RST_MODE_C 8'h04
`define PMA_RST_MODE_D 8'h1b
`define PMA_RST_STATUS 8'h3f
`define PMA_RST_MASK 8'h3f

`define PMA_LP_MODE_B 8'h06
`define PMA_HP_MODE_B 8'h0f
`define PMA_LP_MODE_C 8'h00
`define PMA_HP_MODE_C 8'h04
`define PMA_LP_MODE_D 8'h14
`define PMA_HP_MODE_D 8'h1b

`define PMA_ALARM_BITS 8'h3f
`define PMA_SUMMARY_BIT 0

`endif

// ===== rtl/pma_pkg.sv
/*
 * Types for the operating-mode and alarm register slice.
 * Assumes pma_defs.svh for all numbers.
 */
package pma_pkg;

   typedef enum logic [1:0] {
      PMA_MODE_MIXED = 2'h0,
      PMA_MODE_LOW = 2'h1,
      PMA_MODE_HIGH = 2'h2
   } pma_mode_t;

   typedef struct packed {
      logic [7:0] mode_b;
      logic [7:0] mode_c;
      logic [7:0] mode_d;
      logic [7:0] status;
      logic [7:0] mask;
      logic summary;
      logic [7:0] rdata;
      logic cal_status;
      logic [1:0] mode;
   } pma_state_t;

   typedef struct packed {
      logic wr;
      logic rd;
      logic [11:0] addr;
      logic [7:0] wdata;
   } pma_req_t;

endpackage : pma_pkg

// ===== rtl/pma_regs.sv
/*
 * Operating-mode registers, alarm status/mask and alarm summary, with the
 * calibration-status pin mux.
 * Assumes a serial control port decoder on clk_i presents single-cycle read and
 * write strobes; alarm event inputs are synchronous to clk_i.
 * Assumes the calibration source cal_done_i is also a clk_i level, so no
 * synchroniser sits in front of it or of the alarm events.
 * Limitation: mode codes are stored as written; a mixed or reserved set is only
 * reported through mode_o, never corrected, so software keeps the code sets paired.
 * The summary and the pin are registered from next-state values, so both move one
 * clock after the event, the clear or the mask write that causes the change.
 */
`timescale 1ns/1ps
`default_nettype none
`include "pma_defs.svh"

module pma_regs (
   // clock and reset
   input wire logic clk_i,
   input wire logic srst_i,
   // register access
   input wire pma_pkg::pma_req_t req_i,
   output logic [7:0] rdata_o,
   // alarm events and pin control
   input wire logic [7:0] alarm_set_i,
   input wire logic cal_status_sel_i,
   input wire logic cal_done_i,
   // mode view for the analog core, alarm summary and calibration-status pin
   output logic [7:0] perf_mode_code_b_o,
   output logic [7:0] perf_mode_code_c_o,
   output logic [7:0] perf_mode_code_d_o,
   output pma_pkg::pma_mode_t mode_o,
   output logic alarm_summary_o,
   output logic cal_status_pin_o
);

   pma_pkg::pma_state_t s_q;
   pma_pkg::pma_state_t s_d;

   // write strobes, one per writable register
   logic wr_mode_b;
   logic wr_mode_c;
   logic wr_mode_d;
   logic wr_status;
   logic wr_mask;

   // next-state alarm view shared by the registers and the summary
   logic [7:0] nstat;
   logic [7:0] nmask;
   logic [7:0] live;

   // register address compare, used by every decode below
   function automatic logic hit(input logic [11:0] a, input logic [11:0] ofs);
      hit = (a == ofs);
   endfunction : hit

   // reserved or mixed code sets fall to the mixed class
   function automatic pma_pkg::pma_mode_t mode_of(
      input logic [7:0] b,
      input logic [7:0] c,
      input logic [7:0] d
   );
      if (b == `PMA_LP_MODE_B && c == `PMA_LP_MODE_C && d == `PMA_LP_MODE_D) begin
         mode_of = pma_pkg::PMA_MODE_LOW;
      end else if (b == `PMA_HP_MODE_B && c == `PMA_HP_MODE_C
          && d == `PMA_HP_MODE_D) begin
         mode_of = pma_pkg::PMA_MODE_HIGH;
      end else begin
         mode_of = pma_pkg::PMA_MODE_MIXED;
      end
   endfunction : mode_of

   // write one clears
   // new events win over a same-cycle clear, so no alarm is lost
   function automatic logic [7:0] next_status(
      input logic [7:0] cur,
      input logic [7:0] clr,
      input logic [7:0] set
   );
      next_status = ((cur & ~clr) | set) & `PMA_ALARM_BITS;
   endfunction : next_status

   // unmapped addresses read as zero
   function automatic logic [7:0] read_mux(
      input logic [11:0] a,
      input pma_pkg::pma_state_t s
   );
      unique case (1'b1)
         hit(a, `PMA_OFS_MODE_B): begin
            read_mux = s.mode_b;
         end
         hit(a, `PMA_OFS_MODE_C): begin
            read_mux = s.mode_c;
         end
         hit(a, `PMA_OFS_MODE_D): begin
            read_mux = s.mode_d;
         end
         hit(a, `PMA_OFS_SUMMARY): begin
            read_mux = {7'h00, s.summary};
         end
         hit(a, `PMA_OFS_STATUS): begin
            read_mux = s.status;
         end
         hit(a, `PMA_OFS_MASK): begin
            read_mux = s.mask;
         end
         default: begin
            read_mux = 8'h00;
         end
      endcase
   endfunction : read_mux

   // the summary address has no strobe, so writes to it fall away
   assign wr_mode_b = req_i.wr && hit(req_i.addr, `PMA_OFS_MODE_B);
   assign wr_mode_c = req_i.wr && hit(req_i.addr, `PMA_OFS_MODE_C);
   assign wr_mode_d = req_i.wr && hit(req_i.addr, `PMA_OFS_MODE_D);
   assign wr_status = req_i.wr && hit(req_i.addr, `PMA_OFS_STATUS);
   assign wr_mask = req_i.wr && hit(req_i.addr, `PMA_OFS_MASK);

   assign nstat = next_status(s_q.status, wr_status ? req_i.wdata : 8'h00, alarm_set_i);

   // mask writes, reserved bits kept zero
   assign nmask = wr_mask ? (req_i.wdata & `PMA_ALARM_BITS) : s_q.mask;

   for (genvar i = 0; i < 8; i++) begin : g_live
      assign live[i] = nstat[i] & ~nmask[i];
   end

   always_comb begin
      s_d = s_q;
      if (wr_mode_b) begin
         s_d.mode_b = req_i.wdata;
      end
      if (wr_mode_c) begin
         s_d.mode_c = req_i.wdata;
      end
      if (wr_mode_d) begin
         s_d.mode_d = req_i.wdata;
      end
      s_d.status = nstat;
      s_d.mask = nmask;
      s_d.summary = |live;
      s_d.cal_status = cal_status_sel_i ? s_d.summary : cal_done_i;
      // decoded mode only; mixing is flagged, not corrected
      s_d.mode = mode_of(s_d.mode_b, s_d.mode_c, s_d.mode_d);
      // read data stands one cycle, zero between reads
      s_d.rdata = req_i.rd ? read_mux(req_i.addr, s_q) : 8'h00;
      if (srst_i) begin
         s_d.mode_b = `PMA_RST_MODE_B;
         s_d.mode_c = `PMA_RST_MODE_C;
         s_d.mode_d = `PMA_RST_MODE_D;
         s_d.status = `PMA_RST_STATUS;
         s_d.mask = `PMA_RST_MASK;
         s_d.summary = 1'b0;
         s_d.rdata = 8'h00;
         s_d.cal_status = 1'b0;
         s_d.mode = pma_pkg::PMA_MODE_HIGH;
      end
   end

   always_ff @(posedge clk_i) begin
      s_q <= s_d;
   end

   assign rdata_o = s_q.rdata;
   assign perf_mode_code_b_o = s_q.mode_b;
   assign perf_mode_code_c_o = s_q.mode_c;
   assign perf_mode_code_d_o = s_q.mode_d;
   assign mode_o = pma_pkg::pma_mode_t'(s_q.mode);
   assign alarm_summary_o = s_q.summary;
   assign cal_status_pin_o = s_q.cal_status;

endmodule : pma_regs
`default_nettype wire

// ===== test/pma_regs_assertions.sv
/* port assertions for pma_regs
   assumes pma_defs.svh and pma_pkg compiled first */
`timescale 1ns/1ps
`default_nettype none
`include "pma_defs.svh"
module pma_regs_assertions (
   // clock and reset
   input wire logic clk_i,
   input wire logic srst_i,
   // watched ports
   input wire pma_pkg::pma_req_t req_i,
   input wire logic [7:0] rdata_o,
   input wire logic [7:0] alarm_set_i,
   input wire logic cal_status_sel_i,
   input wire logic cal_done_i,
   input wire logic [7:0] perf_mode_code_b_o,
   input wire logic [7:0] perf_mode_code_c_o,
   input wire logic [7:0] perf_mode_code_d_o,
   input wire pma_pkg::pma_mode_t mode_o,
   input wire logic alarm_summary_o,
   input wire logic cal_status_pin_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (srst_i);
   logic wm;
   assign wm = req_i.wr && req_i.addr == `PMA_OFS_MASK;
   reset_vals_a: assert property ($past(srst_i) |-> perf_mode_code_b_o == 8'h0f
      && perf_mode_code_d_o == 8'h1b && mode_o == pma_pkg::PMA_MODE_HIGH) else $error("reset");
   b_write_a: assert property (req_i.wr && req_i.addr == `PMA_OFS_MODE_B
      |=> perf_mode_code_b_o == $past(req_i.wdata)) else $error("mode b write");
   low_mode_a: assert property (perf_mode_code_b_o == 8'h06 && perf_mode_code_c_o == 8'h00
      && perf_mode_code_d_o == 8'h14 |-> mode_o == pma_pkg::PMA_MODE_LOW) else $error("low");
   pin_route_a: assert property (cal_status_sel_i |=>
      cal_status_pin_o == alarm_summary_o) else $error("pin route");
   summary_ro_a: assert property (req_i.rd && req_i.addr == `PMA_OFS_SUMMARY
      |=> rdata_o[7:1] == 7'h00) else $error("summary upper bits");
   unmasked_set_a: assert property (wm && req_i.wdata == 8'h00 && alarm_set_i[5:0] != 6'h00
      |=> alarm_summary_o) else $error("summary not set");
   all_masked_a: assert property (wm && req_i.wdata[5:0] == 6'h3f
      |=> !alarm_summary_o) else $error("masked summary");
   w1c_clear_a: assert property (req_i.wr && req_i.addr == `PMA_OFS_STATUS
      && req_i.wdata == 8'h3f && alarm_set_i == 8'h00 |=> !alarm_summary_o) else $error("w1c");
endmodule : pma_regs_assertions
bind pma_regs pma_regs_assertions u_chk (.*);
`default_nettype wire

// ===== test/pma_regs_tb_top.sv
/* self-checking bench for pma_regs
   assumes pma_defs.svh and pma_pkg from rtl */
`timescale 1ns/1ps
`default_nettype none
`include "pma_defs.svh"
module pma_regs_tb_top;
   logic clk_i = 1'b0;
   logic srst_i = 1'b1;
   pma_pkg::pma_req_t req = '0;
   logic [7:0] aset = 8'h00;
   logic sel = 1'b0;
   logic done = 1'b0;
   logic [7:0] rdata, cb, cc, cd;
   pma_pkg::pma_mode_t mode;
   logic summ, pin;
   int err_count = 0;
   int compares = 0;
   pma_regs dut (.clk_i(clk_i), .srst_i(srst_i), .req_i(req), .rdata_o(rdata),
      .alarm_set_i(aset), .cal_status_sel_i(sel), .cal_done_i(done),
      .perf_mode_code_b_o(cb), .perf_mode_code_c_o(cc), .perf_mode_code_d_o(cd),
      .mode_o(mode), .alarm_summary_o(summ), .cal_status_pin_o(pin));
   initial begin
      forever #4 clk_i = ~clk_i;
   end
   task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
      compares++;
      if (seen !== exp) begin
         err_count++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk
   task automatic tick();
      @(posedge clk_i);
      #1;
   endtask : tick
   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
      tick();
      req.wr = 1'b0;
      tick();
   endtask : wr
   task automatic rd(input logic [11:0] a, input logic [7:0] exp);
      req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
      tick();
      chk("rdata", rdata, exp);
      req.rd = 1'b0;
      tick();
   endtask : rd
   task automatic setm(input logic [7:0] b, input logic [7:0] c, input logic [7:0] d);
      wr(`PMA_OFS_MODE_B, b);
      wr(`PMA_OFS_MODE_C, c);
      wr(`PMA_OFS_MODE_D, d);
   endtask : setm
   task automatic t_reset();
      chk("mode", {6'h00, mode}, 8'h02);
      rd(`PMA_OFS_MODE_B, 8'h0f);
      rd(`PMA_OFS_MODE_C, 8'h04);
      rd(`PMA_OFS_MODE_D, 8'h1b);
      rd(`PMA_OFS_STATUS, 8'h3f);
      rd(`PMA_OFS_MASK, 8'h3f);
      rd(`PMA_OFS_SUMMARY, 8'h00);
      $display("test reset done");
   endtask : t_reset
   task automatic t_mode();
      // low power codes assume a rate of at most 1 GSPS
      // calibration and link enables lie outside, held off here
      setm(8'h06, 8'h00, 8'h14);
      chk("mode", {6'h00, mode}, 8'h01);
      chk("code b", cb, 8'h06);
      chk("code c", cc, 8'h00);
      chk("code d", cd, 8'h14);
      rd(`PMA_OFS_MODE_C, 8'h00);
      setm(8'h0f, 8'h04, 8'h1b);
      // calibration after the change lies outside this block
      chk("mode", {6'h00, mode}, 8'h02);
      chk("code b", cb, 8'h0f);
      chk("code c", cc, 8'h04);
      chk("code d", cd, 8'h1b);
      $display("test mode done");
   endtask : t_mode
   task automatic t_alarm();
      aset = 8'h04;
      wr(`PMA_OFS_MASK, 8'h00);
      aset = 8'h00;
      chk("summary", {7'h00, summ}, 8'h01);
      rd(`PMA_OFS_SUMMARY, 8'h01);
      sel = 1'b1;
      tick();
      chk("pin", {7'h00, pin}, 8'h01);
      sel = 1'b0;
      tick();
      chk("pin", {7'h00, pin}, 8'h00);
      done = 1'b1;
      tick();
      chk("pin", {7'h00, pin}, 8'h01);
      done = 1'b0;
      wr(`PMA_OFS_MASK, 8'h3f);
      chk("summary", {7'h00, summ}, 8'h00);
      wr(`PMA_OFS_MASK, 8'h00);
      wr(`PMA_OFS_STATUS, 8'h3f);
      rd(`PMA_OFS_STATUS, 8'h00);
      chk("summary", {7'h00, summ}, 8'h00);
      aset = 8'h01;
      wr(`PMA_OFS_STATUS, 8'h01);
      aset = 8'h00;
      rd(`PMA_OFS_STATUS, 8'h01);
      chk("summary", {7'h00, summ}, 8'h01);
      wr(`PMA_OFS_STATUS, 8'h01);
      rd(`PMA_OFS_STATUS, 8'h00);
      wr(`PMA_OFS_SUMMARY, 8'hff);
      rd(`PMA_OFS_SUMMARY, 8'h00);
      rd(12'h123, 8'h00);
      $display("test alarm done");
   endtask : t_alarm
   task automatic final_report();
      $display("checks %0d mismatches %0d", compares, err_count);
      if (err_count == 0 && compares > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : final_report
   initial begin
      #20000;
      err_count++;
      final_report();
   end
   initial begin
      repeat (10) @(posedge clk_i);
      #1 srst_i = 1'b0;
      t_reset();
      t_mode();
      t_alarm();
      final_report();
   end
endmodule : pma_regs_tb_top
`default_nettype wire
